/* design/semph_pkg.sv */
// Constants, timing counts and state codes for the semaphore port controller.
// Assumes a 50 MHz system clock and a semaphore port wired to the controller pins.
package semph_pkg;

    // Clock and pin timing
    localparam int CLK_PERIOD_NS  = 20;
    localparam int WR_PULSE_NS    = 40;
    localparam int READ_ACC_NS    = 40;
    localparam int RECOVER_NS     = 40;
    // Least times round up to whole cycles
    localparam int WR_PULSE_CYC   = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_ACC_CYC   = (READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC    = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Port geometry
    localparam int FLAG_COUNT     = 8;
    localparam int IDX_W          = 3;
    localparam int DATA_W         = 8;
    localparam int ADDR_W         = 17;
    localparam int POLL_LIMIT     = 16;
    localparam int CNT_W          = 3;
    localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;

    // Flag levels: active low token
    localparam logic FLAG_TAKEN   = 1'b0;
    localparam logic FLAG_FREE    = 1'b1;

    typedef logic [CNT_W-1:0] semph_cnt_t;

    typedef enum logic [1:0] {
        SEMPH_OP_CLAIM   = 2'b00,
        SEMPH_OP_RELEASE = 2'b01,
        SEMPH_OP_PROBE   = 2'b10
    } semph_op_e;

    typedef enum logic [1:0] {
        CYC_IDLE    = 2'b00,
        CYC_ACTIVE  = 2'b01,
        CYC_RECOVER = 2'b10
    } semph_cyc_e;

    typedef enum logic [2:0] {
        M_INIT     = 3'b000,
        M_IDLE     = 3'b001,
        M_CLAIM_WR = 3'b010,
        M_CLAIM_RD = 3'b011,
        M_WITHDRAW = 3'b100,
        M_RELEASE  = 3'b101,
        M_PROBE    = 3'b110
    } semph_main_e;

endpackage : semph_pkg

/* design/semph_cyc_if.sv */
// Carrier between the command sequencer and the pin cycle runner.
// Assumes both ends share sys_clk; req is a one-cycle pulse.
`timescale 1ns/1ps
interface semph_cyc_if;
    logic                        req;
    logic                        wr;
    logic                        wbit;
    logic [semph_pkg::IDX_W-1:0] idx;
    logic                        done;
    logic                        rbit;

    modport issuer (output req, output wr, output wbit, output idx,
                    input  done, input rbit);
    modport runner (input  req, input  wr, input  wbit, input  idx,
                    output done, output rbit);
endinterface : semph_cyc_if

/* design/semph_cycle.sv */
// Runs one semaphore read or write cycle on the port pins.
// Assumes one request at a time; pins are synchronous to sys_clk.
`timescale 1ns/1ps
module semph_cycle #(
    parameter int ADDR_W = semph_pkg::ADDR_W,
    parameter int DATA_W = semph_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    // Request from the sequencer
    semph_cyc_if.runner            cyc,
    // Port pins
    output logic                   sel_n,
    output logic                   ce_n,
    output logic                   rw_n,
    output logic                   oe_n,
    output logic [ADDR_W-1:0]      addr,
    output logic [DATA_W-1:0]      data_out,
    output logic                   data_oe,
    input  wire logic [DATA_W-1:0] data_in
);
    typedef struct packed {
        semph_pkg::semph_cyc_e state;
        semph_pkg::semph_cnt_t cnt;
        logic                  wr;
        logic                  sel_n;
        logic                  ce_n;
        logic                  rw_n;
        logic                  oe_n;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     dout;
        logic                  doe;
        logic                  rbit;
        logic                  done;
    } semph_cyc_s;

    semph_cyc_s s_q;
    semph_cyc_s s_d;

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        unique case (s_q.state)
            semph_pkg::CYC_IDLE: begin
                if (cyc.req) begin
                    s_d.state = semph_pkg::CYC_ACTIVE;
                    s_d.wr    = cyc.wr;
                    s_d.sel_n = 1'b0;
                    s_d.rw_n  = ~cyc.wr;
                    s_d.oe_n  = cyc.wr;
                    s_d.addr  = ADDR_W'(cyc.idx);
                    s_d.dout  = DATA_W'(cyc.wbit);
                    s_d.doe   = cyc.wr;
                    s_d.cnt   = cyc.wr ? semph_pkg::CNT_W'(semph_pkg::WR_PULSE_CYC - 1)
                                       : semph_pkg::CNT_W'(semph_pkg::READ_ACC_CYC - 1);
                end
            end
            semph_pkg::CYC_ACTIVE: begin
                if (s_q.cnt == '0) begin
                    if (!s_q.wr) begin
                        s_d.rbit = data_in[0];
                    end
                    s_d.state = semph_pkg::CYC_RECOVER;
                    s_d.sel_n = 1'b1;
                    s_d.rw_n  = 1'b1;
                    s_d.oe_n  = 1'b1;
                    s_d.doe   = 1'b0;
                    s_d.cnt   = semph_pkg::CNT_W'(semph_pkg::RECOVER_CYC - 1);
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
            semph_pkg::CYC_RECOVER: begin
                if (s_q.cnt == '0) begin
                    s_d.state = semph_pkg::CYC_IDLE;
                    s_d.done  = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
            default: begin
                s_d.state = semph_pkg::CYC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q       <= '0;
            s_q.state <= semph_pkg::CYC_IDLE;
            s_q.sel_n <= 1'b1;
            s_q.ce_n  <= 1'b1;
            s_q.rw_n  <= 1'b1;
            s_q.oe_n  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign sel_n    = s_q.sel_n;
    assign ce_n     = s_q.ce_n;
    assign rw_n     = s_q.rw_n;
    assign oe_n     = s_q.oe_n;
    assign addr     = s_q.addr;
    assign data_out = s_q.dout;
    assign data_oe  = s_q.doe;
    assign cyc.done = s_q.done;
    assign cyc.rbit = s_q.rbit;

    property p_ce_off_in_sel;
        @(posedge sys_clk) disable iff (!resetn)
        !sel_n |-> ce_n;
    endproperty
    a_ce_off_in_sel: assert property (p_ce_off_in_sel)
        else $error("memory enable active during semaphore access");

    property p_strobe_needs_sel;
        @(posedge sys_clk) disable iff (!resetn)
        (!rw_n || !oe_n) |-> (!sel_n && (rw_n != oe_n));
    endproperty
    a_strobe_needs_sel: assert property (p_strobe_needs_sel)
        else $error("strobe without semaphore select or both strobes");

    property p_index_only;
        @(posedge sys_clk) disable iff (!resetn)
        !sel_n |-> (addr[ADDR_W-1:semph_pkg::IDX_W] == '0);
    endproperty
    a_index_only: assert property (p_index_only)
        else $error("upper address lines not held low");

    property p_write_bit0;
        @(posedge sys_clk) disable iff (!resetn)
        data_oe |-> (!rw_n && data_out[DATA_W-1:1] == '0);
    endproperty
    a_write_bit0: assert property (p_write_bit0)
        else $error("write data outside a write or on upper bits");

    property p_write_pulse;
        @(posedge sys_clk) disable iff (!resetn)
        $fell(rw_n) |-> (!rw_n && !sel_n) ##1 (!rw_n && !sel_n) ##1 (rw_n && sel_n);
    endproperty
    a_write_pulse: assert property (p_write_pulse)
        else $error("write pulse length wrong");

    property p_read_gap;
        @(posedge sys_clk) disable iff (!resetn)
        $rose(oe_n) |-> (oe_n && sel_n)[*2];
    endproperty
    a_read_gap: assert property (p_read_gap)
        else $error("no select gap between reads");

    property p_cycle_done;
        @(posedge sys_clk) disable iff (!resetn)
        (cyc.req && s_q.state == semph_pkg::CYC_IDLE) |-> !cyc.done[*5] ##1 cyc.done;
    endproperty
    a_cycle_done: assert property (p_cycle_done)
        else $error("cycle did not finish in five cycles");

    c_write: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(rw_n));
    c_read:  cover property (@(posedge sys_clk) disable iff (!resetn) $fell(oe_n));
endmodule : semph_cycle

/* design/semph_ctrl.sv */
// Host controller for one port of a dual-port semaphore block.
// Assumes the other port is run by an independent party; pins are synchronous.
`timescale 1ns/1ps
module semph_ctrl #(
    parameter int ADDR_W     = semph_pkg::ADDR_W,
    parameter int DATA_W     = semph_pkg::DATA_W,
    parameter int POLL_LIMIT = semph_pkg::POLL_LIMIT
) (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        resetn,
    // User command
    input  wire logic                        cmd_valid,
    input  wire logic [1:0]                  cmd_op,
    input  wire logic [semph_pkg::IDX_W-1:0] cmd_index,
    output logic                             cmd_ready,
    // User result
    output logic                             cmd_done,
    output logic                             granted,
    output logic                             flag_value,
    output logic                             init_done,
    // Semaphore port pins
    output logic                             semaphore_select_n,
    output logic                             ce_n,
    output logic                             rw_n,
    output logic                             oe_n,
    output logic [ADDR_W-1:0]                addr,
    output logic [DATA_W-1:0]                data_out,
    output logic                             data_oe,
    input  wire logic [DATA_W-1:0]           data_in
);
    localparam int TRY_W = $clog2(POLL_LIMIT + 1);
    localparam logic [TRY_W-1:0] TRY_LAST = TRY_W'(POLL_LIMIT - 1);

    typedef struct packed {
        semph_pkg::semph_main_e      state;
        logic [semph_pkg::IDX_W-1:0] idx;
        logic [TRY_W-1:0]            tries;
        logic                        pend;
        logic                        req;
        logic                        wr;
        logic                        wbit;
        logic                        ready;
        logic                        done;
        logic                        granted;
        logic                        flag;
        logic                        init_done;
    } semph_ctrl_s;

    semph_ctrl_s s_q;
    semph_ctrl_s s_d;
    semph_cyc_if cyc ();

    semph_cycle #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) u_cycle (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .cyc      (cyc.runner),
        .sel_n    (semaphore_select_n),
        .ce_n     (ce_n),
        .rw_n     (rw_n),
        .oe_n     (oe_n),
        .addr     (addr),
        .data_out (data_out),
        .data_oe  (data_oe),
        .data_in  (data_in)
    );

    always_comb begin
        s_d      = s_q;
        s_d.req  = 1'b0;
        s_d.done = 1'b0;
        unique case (s_q.state)
            semph_pkg::M_INIT: begin
                if (!s_q.pend) begin
                    s_d.req  = 1'b1;
                    s_d.pend = 1'b1;
                    s_d.wr   = 1'b1;
                    s_d.wbit = semph_pkg::FLAG_FREE;
                end else if (cyc.done) begin
                    s_d.pend = 1'b0;
                    if (s_q.idx == semph_pkg::IDX_LAST) begin
                        s_d.state     = semph_pkg::M_IDLE;
                        s_d.ready     = 1'b1;
                        s_d.init_done = 1'b1;
                    end else begin
                        s_d.idx = s_q.idx + 1'b1;
                    end
                end
            end
            semph_pkg::M_IDLE: begin
                if (cmd_valid && s_q.ready) begin
                    s_d.ready = 1'b0;
                    s_d.idx   = cmd_index;
                    s_d.tries = '0;
                    unique case (cmd_op)
                        semph_pkg::SEMPH_OP_CLAIM:   s_d.state = semph_pkg::M_CLAIM_WR;
                        semph_pkg::SEMPH_OP_RELEASE: s_d.state = semph_pkg::M_RELEASE;
                        default:                     s_d.state = semph_pkg::M_PROBE;
                    endcase
                end
            end
            semph_pkg::M_CLAIM_WR: begin
                if (!s_q.pend) begin
                    s_d.req  = 1'b1;
                    s_d.pend = 1'b1;
                    s_d.wr   = 1'b1;
                    s_d.wbit = semph_pkg::FLAG_TAKEN;
                end else if (cyc.done) begin
                    s_d.pend  = 1'b0;
                    s_d.state = semph_pkg::M_CLAIM_RD;
                end
            end
            semph_pkg::M_CLAIM_RD: begin
                if (!s_q.pend) begin
                    s_d.req  = 1'b1;
                    s_d.pend = 1'b1;
                    s_d.wr   = 1'b0;
                end else if (cyc.done) begin
                    s_d.pend = 1'b0;
                    s_d.flag = cyc.rbit;
                    if (cyc.rbit == semph_pkg::FLAG_TAKEN) begin
                        s_d.state   = semph_pkg::M_IDLE;
                        s_d.granted = 1'b1;
                        s_d.done    = 1'b1;
                        s_d.ready   = 1'b1;
                    end else if (s_q.tries == TRY_LAST) begin
                        s_d.state = semph_pkg::M_WITHDRAW;
                    end else begin
                        s_d.tries = s_q.tries + 1'b1;
                    end
                end
            end
            semph_pkg::M_WITHDRAW,
            semph_pkg::M_RELEASE: begin
                if (!s_q.pend) begin
                    s_d.req  = 1'b1;
                    s_d.pend = 1'b1;
                    s_d.wr   = 1'b1;
                    s_d.wbit = semph_pkg::FLAG_FREE;
                end else if (cyc.done) begin
                    s_d.pend    = 1'b0;
                    s_d.state   = semph_pkg::M_IDLE;
                    s_d.granted = 1'b0;
                    s_d.done    = 1'b1;
                    s_d.ready   = 1'b1;
                end
            end
            semph_pkg::M_PROBE: begin
                if (!s_q.pend) begin
                    s_d.req  = 1'b1;
                    s_d.pend = 1'b1;
                    s_d.wr   = 1'b0;
                end else if (cyc.done) begin
                    s_d.pend    = 1'b0;
                    s_d.flag    = cyc.rbit;
                    s_d.state   = semph_pkg::M_IDLE;
                    s_d.granted = 1'b0;
                    s_d.done    = 1'b1;
                    s_d.ready   = 1'b1;
                end
            end
            default: begin
                s_d.state = semph_pkg::M_INIT;
                s_d.pend  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q       <= '0;
            s_q.state <= semph_pkg::M_INIT;
            s_q.flag  <= semph_pkg::FLAG_FREE;
        end else begin
            s_q <= s_d;
        end
    end

    assign cyc.req    = s_q.req;
    assign cyc.wr     = s_q.wr;
    assign cyc.wbit   = s_q.wbit;
    assign cyc.idx    = s_q.idx;
    assign cmd_ready  = s_q.ready;
    assign cmd_done   = s_q.done;
    assign granted    = s_q.granted;
    assign flag_value = s_q.flag;
    assign init_done  = s_q.init_done;

    property p_init_frees;
        @(posedge sys_clk) disable iff (!resetn)
        (s_q.state == semph_pkg::M_INIT && s_q.req) |-> (s_q.wr && s_q.wbit && !s_q.ready);
    endproperty
    a_init_frees: assert property (p_init_frees)
        else $error("start-up write is not a release");

    property p_init_all;
        @(posedge sys_clk) disable iff (!resetn)
        $rose(s_q.init_done) |-> (s_q.idx == semph_pkg::IDX_LAST && s_q.ready);
    endproperty
    a_init_all: assert property (p_init_all)
        else $error("start-up ended before the last semaphore");

    property p_claim_write_zero;
        @(posedge sys_clk) disable iff (!resetn)
        (s_q.state == semph_pkg::M_CLAIM_WR && s_q.req) |-> (s_q.wr && !s_q.wbit);
    endproperty
    a_claim_write_zero: assert property (p_claim_write_zero)
        else $error("claim does not write zero");

    property p_read_after_write;
        @(posedge sys_clk) disable iff (!resetn)
        (s_q.state == semph_pkg::M_CLAIM_WR && cyc.done)
            |=> (s_q.state == semph_pkg::M_CLAIM_RD) ##1 (s_q.req && !s_q.wr);
    endproperty
    a_read_after_write: assert property (p_read_after_write)
        else $error("claim write not followed by read back");

    property p_withdraw;
        @(posedge sys_clk) disable iff (!resetn)
        (s_q.state == semph_pkg::M_CLAIM_RD && cyc.done && cyc.rbit && s_q.tries == TRY_LAST)
            |=> (s_q.state == semph_pkg::M_WITHDRAW) ##1 (s_q.req && s_q.wr && s_q.wbit);
    endproperty
    a_withdraw: assert property (p_withdraw)
        else $error("failed claim not withdrawn");

    property p_grant_on_zero;
        @(posedge sys_clk) disable iff (!resetn)
        $rose(s_q.granted) |-> (s_q.done && !s_q.flag && $past(s_q.state) == semph_pkg::M_CLAIM_RD);
    endproperty
    a_grant_on_zero: assert property (p_grant_on_zero)
        else $error("grant without reading zero after claim");

    c_granted:   cover property (@(posedge sys_clk) disable iff (!resetn) $rose(s_q.granted));
    c_withdrawn: cover property (@(posedge sys_clk) disable iff (!resetn)
                                 s_q.state == semph_pkg::M_WITHDRAW && cyc.done);
    c_released:  cover property (@(posedge sys_clk) disable iff (!resetn)
                                 s_q.state == semph_pkg::M_RELEASE && cyc.done);
endmodule : semph_ctrl

/* tb/semph_dev_model.sv */
// Behavioural dual-port semaphore block: left port on controller pins, right port on a strobe.
// Assumes pins change just after sys_clk rises; no reset, so start-up state is left owned.
`timescale 1ns/1ps
module semph_dev_model (
    // Clock
    input  wire logic        sys_clk,
    // Left port pins
    input  wire logic        sel_n,
    input  wire logic        ce_n,
    input  wire logic        rw_n,
    input  wire logic        oe_n,
    input  wire logic [16:0] addr,
    input  wire logic [7:0]  din,
    output logic [7:0]       dout,
    // Right port
    input  wire logic        r_we,
    input  wire logic [2:0]  r_idx,
    input  wire logic        r_bit,
    output logic             r_flag
);
    logic [7:0] req_l = 8'h00;
    logic [7:0] req_r = 8'hFF;
    logic [7:0] own_l = 8'hFF;
    logic [7:0] own_r = 8'h00;
    logic       act_q = 1'b0;
    logic       lat_q = 1'b1;
    wire        lw    = !sel_n && ce_n && !rw_n;
    wire        rd    = !sel_n && ce_n && !oe_n;

    assign r_flag = !own_r[r_idx];
    assign dout   = rd ? {8{lat_q}} : ~{8{lat_q}};

    always @(posedge sys_clk) begin : upd
        logic l;
        logic r;
        act_q <= rd;
        if (rd && !act_q) lat_q <= !own_l[addr[2:0]];
        for (int i = 0; i < 8; i++) begin
            l = (lw && addr[2:0] == i) ? din[0] : req_l[i];
            r = (r_we && r_idx == i) ? r_bit : req_r[i];
            req_l[i] <= l;
            req_r[i] <= r;
            if (own_l[i] && l) begin
                own_l[i] <= 1'b0;
                own_r[i] <= !r;
            end else if (own_r[i] && r) begin
                own_r[i] <= 1'b0;
                own_l[i] <= !l;
            end else if (!own_l[i] && !own_r[i]) begin
                own_l[i] <= !l;
                own_r[i] <= l && !r;
            end
        end
    end
endmodule : semph_dev_model

/* tb/semph_ctrl_tb.sv */
// Self-checking bench for the semaphore port controller against a device model.
// Assumes the design package is compiled first; right port is driven by the bench.
`timescale 1ns/1ps
module semph_ctrl_tb;
    logic sys_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, r_we = 1'b0, r_bit = 1'b1;
    logic [1:0] cmd_op = 2'h0;
    logic [2:0] cmd_index = 3'h0, r_idx = 3'h0;
    logic cmd_ready, cmd_done, granted, flag_value, init_done, sel_n, ce_n, rw_n, oe_n;
    logic data_oe, r_flag;
    logic [16:0] addr;
    logic [7:0]  data_out, data_in;
    int fail_count = 0, checks = 0, n;

    always #10 sys_clk = ~sys_clk;

    semph_ctrl #(.POLL_LIMIT(2)) dut (
        .sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_index(cmd_index), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
        .granted(granted), .flag_value(flag_value), .init_done(init_done),
        .semaphore_select_n(sel_n), .ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n), .addr(addr),
        .data_out(data_out), .data_oe(data_oe), .data_in(data_in));

    semph_dev_model dev (
        .sys_clk(sys_clk), .sel_n(sel_n), .ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n),
        .addr(addr), .din(data_out), .dout(data_in), .r_we(r_we), .r_idx(r_idx),
        .r_bit(r_bit), .r_flag(r_flag));

    always @(posedge sys_clk) begin
        if (resetn && (ce_n !== 1'b1 || (rw_n === 1'b0 && oe_n === 1'b0))) begin
            fail_count++;
            $display("wrong value strobes expected ce_n 1 seen %b %b %b", ce_n, rw_n, oe_n);
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic run_cmd(input logic [1:0] op, input logic [2:0] idx, output int cyc);
        int w;
        cmd_op = op;
        cmd_index = idx;
        cmd_valid = 1'b1;
        w = 0;
        while (cmd_ready !== 1'b1 && w < 300) begin
            @(posedge sys_clk) #1;
            w++;
        end
        @(posedge sys_clk) #1;
        cmd_valid = 1'b0;
        cyc = 0;
        while (cmd_done !== 1'b1 && cyc < 300) begin
            @(posedge sys_clk) #1;
            cyc++;
        end
    endtask : run_cmd

    task automatic r_write(input logic [2:0] idx, input logic b);
        r_idx = idx;
        r_bit = b;
        r_we = 1'b1;
        @(posedge sys_clk) #1;
        r_we = 1'b0;
        @(posedge sys_clk) #1;
    endtask : r_write

    task automatic t_reset_init();
        int w;
        chk("select in reset", 8'h01, {7'h00, sel_n});
        chk("flag in reset", 8'h01, {7'h00, flag_value});
        chk("ready in reset", 8'h00, {6'h00, cmd_ready, data_oe});
        resetn = 1'b1;
        for (int i = 0; i < 8; i++) r_write(i[2:0], 1'b1);
        w = 0;
        while (init_done !== 1'b1 && w < 300) begin
            @(posedge sys_clk) #1;
            w++;
        end
        chk("init done", 8'h03, {6'h00, init_done, cmd_ready});
        chk("left latches", 8'hFF, dev.req_l);
        chk("left owner", 8'h00, dev.own_l);
        $display("test reset_init done");
    endtask : t_reset_init

    task automatic t_claim_free();
        run_cmd(2'h0, semph_pkg::IDX_LAST, n);
        chk("claim cycles", 8'h0E, n[7:0]);
        chk("claim granted", 8'h01, {7'h00, granted});
        chk("claim flag", 8'h00, {7'h00, flag_value});
        chk("owned set", 8'h80, dev.own_l);
        r_idx = semph_pkg::IDX_LAST;
        #1 chk("other side flag", 8'h01, {7'h00, r_flag});
        run_cmd(2'h3, semph_pkg::IDX_LAST, n);
        chk("probe owned", 8'h00, {6'h00, granted, flag_value});
        run_cmd(2'h1, semph_pkg::IDX_LAST, n);
        chk("release cycles", 8'h07, n[7:0]);
        chk("release owner", 8'h00, dev.own_l);
        $display("test claim_free done");
    endtask : t_claim_free

    task automatic t_handover();
        run_cmd(2'h0, 3'h3, n);
        chk("claim3 granted", 8'h01, {7'h00, granted});
        r_write(3'h3, 1'b0);
        chk("pending flag", 8'h01, {7'h00, r_flag});
        run_cmd(2'h1, 3'h3, n);
        chk("release granted", 8'h00, {7'h00, granted});
        chk("handed over", 8'h00, {7'h00, r_flag});
        run_cmd(2'h2, 3'h3, n);
        chk("probe flag", 8'h01, {7'h00, flag_value});
        run_cmd(2'h0, 3'h3, n);
        chk("fail cycles", 8'h1C, n[7:0]);
        chk("fail granted", 8'h00, {7'h00, granted});
        chk("fail flag", 8'h01, {7'h00, flag_value});
        chk("withdrawn", 8'h01, {7'h00, dev.req_l[3]});
        r_write(3'h3, 1'b1);
        chk("right freed", 8'h01, {7'h00, r_flag});
        run_cmd(2'h0, 3'h3, n);
        chk("reclaim", 8'h01, {7'h00, granted});
        run_cmd(2'h1, 3'h3, n);
        $display("test handover done");
    endtask : t_handover

    task automatic t_probe_ops();
        for (int i = 0; i < 8; i++) begin
            run_cmd({1'b1, i[0]}, i[2:0], n);
            chk("probe cycles", 8'h07, n[7:0]);
            chk("probe free", 8'h01, {6'h00, granted, flag_value});
        end
        chk("no owner", 8'h00, dev.own_l);
        $display("test probe_ops done");
    endtask : t_probe_ops

    task automatic final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    initial begin
        #100000;
        fail_count++;
        $display("wrong value watchdog expected finish seen hang");
        final_report();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        #1 t_reset_init();
        t_claim_free();
        t_handover();
        t_probe_ops();
        final_report();
    end
endmodule : semph_ctrl_tb
